// >>> hdl/sdcmd_map.svh
// Offsets, field positions, reset values and codes of the command decoder
`ifndef SDCMD_MAP_SVH
`define SDCMD_MAP_SVH
// Register byte offsets on the AXI4-Lite port
`define SDC_OFF_CTRL   8'h00
`define SDC_OFF_STAT   8'h04
`define SDC_OFF_MR0    8'h08
`define SDC_OFF_MR1    8'h0C
`define SDC_OFF_MR2    8'h10
`define SDC_OFF_MR3    8'h14
// Control register fields and reset value
`define SDC_CTRL_OTF   0
`define SDC_CTRL_BC4   1
`define SDC_CTRL_WL    2
`define SDC_CTRL_RST   3'h1
// Status register fields
`define SDC_STAT_ERR   8
`define SDC_STAT_OPEN  16
// Address pin positions inside command words
`define SDC_BIT_MPR    2
`define SDC_BIT_AP     10
`define SDC_BIT_BC     12
`define SDC_RTT_LO     9
`define SDC_RTT_HI     10
// Bank code that selects mode register three
`define SDC_BA_MR3     3'h3
// Calibration pattern, one byte per burst, location zero
`define SDC_MPR_PAT0   8'h55
`define SDC_MPR_RSVD   8'h00
// Bus response codes
`define SDC_RESP_OKAY  2'h0
`define SDC_RESP_SLV   2'h2
`endif

// >>> hdl/sdcmd_pkg.sv
// Types shared by the command decoder files
package sdcmd_pkg;
   // Device operating states, one-hot
   typedef enum logic [3:0] {
      ST_NORM = 4'h1,
      ST_PDN  = 4'h2,
      ST_SRF  = 4'h4,
      ST_MPR  = 4'h8
   } sdcmd_state_t;
   // Decoded operations
   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_DES  = 5'h01, OP_NOP  = 5'h02, OP_MRS  = 5'h03,
      OP_REF  = 5'h04, OP_SRE  = 5'h05, OP_SRX  = 5'h06, OP_PDE  = 5'h07,
      OP_PDX  = 5'h08, OP_PRE  = 5'h09, OP_PREA = 5'h0A, OP_ACT  = 5'h0B,
      OP_WR   = 5'h0C, OP_RD   = 5'h0D, OP_ZQCL = 5'h0E, OP_ZQCS = 5'h0F,
      OP_ILL  = 5'h10
   } sdcmd_op_t;
   // Command and address pins as sampled
   typedef struct packed {
      logic        cke;
      logic        cs_b;
      logic        ras_b;
      logic        cas_b;
      logic        we_b;
      logic [2:0]  ba;
      logic [15:0] addr;
   } sdcmd_pins_t;
   // Decoded command toward the core
   typedef struct packed {
      logic        valid;
      sdcmd_op_t   op;
      logic [2:0]  bank;
      logic [15:0] row;
      logic [10:0] col;
      logic        ap;
      logic        bc4;
      logic        mpr;
      logic [7:0]  mpr_data;
   } sdcmd_cmd_t;
endpackage

// >>> hdl/sdcmd_mpr_pat.sv
// Predefined calibration pattern source for multi-purpose register reads
`timescale 1ns/1ns
`include "sdcmd_map.svh"
module sdcmd_mpr_pat (
   input  wire logic [1:0] loc,
   output logic      [7:0] pattern
);
   // Location zero holds the fixed training pattern, the rest read as zero
   always_comb begin
      case (loc)
         2'h0:    pattern = `SDC_MPR_PAT0;
         default: pattern = `SDC_MPR_RSVD;
      endcase
   end
endmodule

// >>> hdl/sdcmd_decode.sv
// Command decoder with mode registers, MPR mode and AXI4-Lite status port
`timescale 1ns/1ns
`include "sdcmd_map.svh"
module sdcmd_decode (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire sdcmd_pkg::sdcmd_pins_t pins_i,
   output sdcmd_pkg::sdcmd_cmd_t       cmd_o,
   output logic [1:0]                  rtt_wr_o,
   output logic                        rtt_nom_only_o,
   output logic                        pwr_down_o,
   output logic                        self_ref_o,
   output logic                        mpr_mode_o,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   // Whole state of the block
   typedef struct packed {
      sdcmd_pkg::sdcmd_state_t st;
      logic                    cke_prev;
      logic [3:0][15:0]        mr;
      logic [7:0]              open;
      logic [2:0]              ctrl;
      logic                    err;
      logic [1:0]              rtt;
      sdcmd_pkg::sdcmd_cmd_t   out;
      logic                    aw_hold;
      logic [7:0]              awaddr;
      logic                    w_hold;
      logic [31:0]             wdata;
      logic [3:0]              wstrb;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
   } sdcmd_reg_t;

   sdcmd_reg_t          st_r;     // Registered state
   sdcmd_reg_t          st_nxt;   // Next state
   sdcmd_pkg::sdcmd_op_t op_now;  // Pin-level operation this cycle
   logic [7:0]          pat;      // Pattern for the selected location
   logic [1:0]          mpr_loc;  // Location in use

   // Pin-level classification of strobes and clock enable history
   function automatic sdcmd_pkg::sdcmd_op_t sdcmd_classify(
      input logic prev, input sdcmd_pkg::sdcmd_pins_t p);
      sdcmd_pkg::sdcmd_op_t o;
      logic [2:0]           s;
      s = {p.ras_b, p.cas_b, p.we_b};
      o = sdcmd_pkg::OP_ILL;
      if (prev && p.cke) begin
         // Clock enable steady high: full truth table
         if (p.cs_b) begin
            o = sdcmd_pkg::OP_DES;
         end else begin
            case (s)
               3'h0:    o = sdcmd_pkg::OP_MRS;
               3'h1:    o = sdcmd_pkg::OP_REF;
               3'h2:    o = p.addr[`SDC_BIT_AP] ? sdcmd_pkg::OP_PREA
                                                : sdcmd_pkg::OP_PRE;
               3'h3:    o = sdcmd_pkg::OP_ACT;
               3'h4:    o = sdcmd_pkg::OP_WR;
               3'h5:    o = sdcmd_pkg::OP_RD;
               3'h6:    o = p.addr[`SDC_BIT_AP] ? sdcmd_pkg::OP_ZQCL
                                                : sdcmd_pkg::OP_ZQCS;
               3'h7:    o = sdcmd_pkg::OP_NOP;
               default: o = sdcmd_pkg::OP_ILL;
            endcase
         end
      end else if (prev) begin
         // Falling clock enable: self refresh or power down entry
         if (!p.cs_b && s == 3'h1) begin
            o = sdcmd_pkg::OP_SRE;
         end else if (p.cs_b || s == 3'h7) begin
            o = sdcmd_pkg::OP_PDE;
         end
      end else if (p.cke) begin
         // Rising clock enable: exit, refined by state later
         if (p.cs_b || s == 3'h7) begin
            o = sdcmd_pkg::OP_PDX;
         end
      end else begin
         o = sdcmd_pkg::OP_NONE;
      end
      return o;
   endfunction

   // Register index of a byte address, 7 when unmapped
   function automatic logic [2:0] sdcmd_sel(input logic [7:0] a);
      case (a)
         `SDC_OFF_CTRL: return 3'h0;
         `SDC_OFF_STAT: return 3'h1;
         `SDC_OFF_MR0:  return 3'h2;
         `SDC_OFF_MR1:  return 3'h3;
         `SDC_OFF_MR2:  return 3'h4;
         `SDC_OFF_MR3:  return 3'h5;
         default:       return 3'h7;
      endcase
   endfunction

   // Location field is only honoured with the MPR bit set
   assign mpr_loc = st_r.mr[3][`SDC_BIT_MPR] ? st_r.mr[3][1:0] : 2'h0;
   assign op_now  = sdcmd_classify(st_r.cke_prev, pins_i);

   // Pattern lookup
   sdcmd_mpr_pat u_pat (
      .loc     (mpr_loc),
      .pattern (pat)
   );

   // Next-state logic: bus slave first, then command decode
   always_comb begin
      sdcmd_pkg::sdcmd_op_t op;
      logic                 legal;
      logic [2:0]           rsel;
      op          = op_now;
      legal       = 1'b1;
      rsel        = 3'h7;
      st_nxt      = st_r;
      st_nxt.cke_prev  = pins_i.cke;
      st_nxt.out.valid = 1'b0;
      // Address and data are held until both have arrived
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_hold = 1'b1;
         st_nxt.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_hold = 1'b1;
         st_nxt.wdata  = s_axi_wdata;
         st_nxt.wstrb  = s_axi_wstrb;
      end
      // Perform the write once both halves are held
      if (st_r.aw_hold && st_r.w_hold) begin
         st_nxt.aw_hold = 1'b0;
         st_nxt.w_hold  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = `SDC_RESP_OKAY;
         case (sdcmd_sel(st_r.awaddr))
            3'h0: begin
               if (st_r.wstrb[0]) begin
                  st_nxt.ctrl = st_r.wdata[2:0];
               end
            end
            3'h1: begin
               // Write one to clear the error flag
               if (st_r.wstrb[1] && st_r.wdata[`SDC_STAT_ERR]) begin
                  st_nxt.err = 1'b0;
               end
            end
            3'h2, 3'h3, 3'h4, 3'h5: begin
               // Mode register shadows are read only
            end
            default: st_nxt.bresp = `SDC_RESP_SLV;
         endcase
      end
      // Response drops when taken
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      // Read: data captured at address acceptance
      if (s_axi_arvalid && s_axi_arready) begin
         rsel          = sdcmd_sel(s_axi_araddr);
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = `SDC_RESP_OKAY;
         st_nxt.rdata  = 32'h0000_0000;
         case (rsel)
            3'h0:    st_nxt.rdata[2:0] = st_r.ctrl;
            3'h1:    st_nxt.rdata = {8'h00, st_r.open, 7'h00, st_r.err, 4'h0, st_r.st};
            3'h2:    st_nxt.rdata[15:0] = st_r.mr[0];
            3'h3:    st_nxt.rdata[15:0] = st_r.mr[1];
            3'h4:    st_nxt.rdata[15:0] = st_r.mr[2];
            3'h5:    st_nxt.rdata[15:0] = st_r.mr[3];
            default: st_nxt.rresp = `SDC_RESP_SLV;
         endcase
      end
      // Command interpretation per device state
      case (st_r.st)
         sdcmd_pkg::ST_NORM: begin
            case (op)
               sdcmd_pkg::OP_SRE: st_nxt.st = sdcmd_pkg::ST_SRF;
               sdcmd_pkg::OP_PDE: st_nxt.st = sdcmd_pkg::ST_PDN;
               sdcmd_pkg::OP_PDX: op = sdcmd_pkg::OP_NONE;
               sdcmd_pkg::OP_MRS: begin
                  if (pins_i.ba[2]) begin
                     // No register behind the upper bank pin: refused, nothing written
                     legal = 1'b0;
                  end else begin
                     // Bank pins pick the mode register
                     st_nxt.mr[pins_i.ba[1:0]] = pins_i.addr;
                     if (pins_i.ba == `SDC_BA_MR3 &&
                         pins_i.addr[`SDC_BIT_MPR]) begin
                        st_nxt.st = sdcmd_pkg::ST_MPR;
                        if (st_r.open != 8'h00) begin
                           st_nxt.err = 1'b1;
                        end
                     end
                  end
               end
               sdcmd_pkg::OP_ACT:  st_nxt.open[pins_i.ba] = 1'b1;
               sdcmd_pkg::OP_PRE:  st_nxt.open[pins_i.ba] = 1'b0;
               sdcmd_pkg::OP_PREA: st_nxt.open = 8'h00;
               sdcmd_pkg::OP_WR, sdcmd_pkg::OP_RD: begin
                  if (pins_i.addr[`SDC_BIT_AP]) begin
                     st_nxt.open[pins_i.ba] = 1'b0;
                  end
               end
               sdcmd_pkg::OP_ILL: legal = 1'b0;
               default: begin
               end
            endcase
         end
         sdcmd_pkg::ST_PDN: begin
            // Only clock enable low or a clean exit is allowed
            if (op == sdcmd_pkg::OP_PDX) begin
               st_nxt.st = sdcmd_pkg::ST_NORM;
            end else if (op != sdcmd_pkg::OP_NONE) begin
               legal = 1'b0;
            end
         end
         sdcmd_pkg::ST_SRF: begin
            if (op == sdcmd_pkg::OP_PDX) begin
               op        = sdcmd_pkg::OP_SRX;
               st_nxt.st = sdcmd_pkg::ST_NORM;
            end else if (op != sdcmd_pkg::OP_NONE) begin
               legal = 1'b0;
            end
         end
         sdcmd_pkg::ST_MPR: begin
            case (op)
               sdcmd_pkg::OP_RD, sdcmd_pkg::OP_NOP, sdcmd_pkg::OP_DES: begin
               end
               sdcmd_pkg::OP_MRS: begin
                  // Only clearing the MPR bit of register three is legal
                  if (pins_i.ba == `SDC_BA_MR3 && !pins_i.addr[`SDC_BIT_MPR]) begin
                     st_nxt.mr[3] = pins_i.addr;
                     st_nxt.st    = sdcmd_pkg::ST_NORM;
                  end else begin
                     legal = 1'b0;
                  end
               end
               default: legal = 1'b0;
            endcase
         end
         default: st_nxt.st = sdcmd_pkg::ST_NORM;
      endcase
      // Illegal commands are dropped and flagged; the set beats a clear
      if (!legal) begin
         st_nxt.err = 1'b1;
      end else if (op != sdcmd_pkg::OP_NONE && op != sdcmd_pkg::OP_DES) begin
         st_nxt.out.valid = 1'b1;
         st_nxt.out.op    = op;
         st_nxt.out.bank  = pins_i.ba;
         st_nxt.out.row   = pins_i.addr;
         st_nxt.out.col   = {pins_i.addr[11], pins_i.addr[9:0]};
         st_nxt.out.ap    = pins_i.addr[`SDC_BIT_AP];
         // Chop from A12 when on the fly, else the fixed setting
         st_nxt.out.bc4   = st_r.ctrl[`SDC_CTRL_OTF] ? !pins_i.addr[`SDC_BIT_BC]
                                                     : st_r.ctrl[`SDC_CTRL_BC4];
         st_nxt.out.mpr   = st_r.st == sdcmd_pkg::ST_MPR && op == sdcmd_pkg::OP_RD;
         st_nxt.out.mpr_data = st_nxt.out.mpr ? pat : 8'h00;
      end
      // Write termination from register two unless leveling
      st_nxt.rtt = st_nxt.ctrl[`SDC_CTRL_WL] ? 2'h0
                   : st_nxt.mr[2][`SDC_RTT_HI:`SDC_RTT_LO];
   end

   // State register; reset pin acts only asynchronously
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r      <= '0;
         st_r.st   <= sdcmd_pkg::ST_NORM;
         st_r.ctrl <= `SDC_CTRL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign cmd_o          = st_r.out;
   assign rtt_wr_o       = st_r.rtt;
   assign rtt_nom_only_o = st_r.ctrl[`SDC_CTRL_WL];
   assign pwr_down_o     = st_r.st == sdcmd_pkg::ST_PDN;
   assign self_ref_o     = st_r.st == sdcmd_pkg::ST_SRF;
   assign mpr_mode_o     = st_r.st == sdcmd_pkg::ST_MPR;
   assign s_axi_awready  = !st_r.aw_hold && !st_r.bvalid;
   assign s_axi_wready   = !st_r.w_hold && !st_r.bvalid;
   assign s_axi_bvalid   = st_r.bvalid;
   assign s_axi_bresp    = st_r.bresp;
   assign s_axi_arready  = !st_r.rvalid;
   assign s_axi_rvalid   = st_r.rvalid;
   assign s_axi_rdata    = st_r.rdata;
   assign s_axi_rresp    = st_r.rresp;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic both_hi;  // Clock enable high now and before, chip select low
   assign both_hi = st_r.cke_prev && pins_i.cke && !pins_i.cs_b;

   a_mr3_write: assert property (
      both_hi && {pins_i.ras_b, pins_i.cas_b, pins_i.we_b} == 3'h0 && pins_i.ba == 3'h3
      |=> st_r.mr[3] == $past(pins_i.addr)) else $error("mr3 not written");
   a_mpr_enter: assert property (
      $rose(mpr_mode_o) |-> $past(op_now == sdcmd_pkg::OP_MRS && pins_i.ba == 3'h3
                                  && pins_i.addr[2])) else $error("bad mpr entry");
   a_loc_ignore: assert property (
      !st_r.mr[3][2] |-> mpr_loc == 2'h0) else $error("mpr location used");
   a_mpr_redirect: assert property (
      mpr_mode_o && op_now == sdcmd_pkg::OP_RD
      |=> cmd_o.valid && cmd_o.mpr && cmd_o.mpr_data == $past(pat)) else $error("no redirect");
   a_mpr_block: assert property (
      mpr_mode_o && op_now == sdcmd_pkg::OP_ACT |=> !cmd_o.valid && st_r.err)
      else $error("act in mpr");
   a_rtt_field: assert property (
      both_hi && op_now == sdcmd_pkg::OP_MRS && pins_i.ba == 3'h2 && !rtt_nom_only_o
      ##1 !rtt_nom_only_o |-> rtt_wr_o == $past(pins_i.addr[10:9])) else $error("rtt wrong");
   a_wl_nom: assert property (
      rtt_nom_only_o ##1 rtt_nom_only_o |-> rtt_wr_o == 2'h0) else $error("rtt in leveling");
   a_wr_decode: assert property (
      !mpr_mode_o && both_hi && {pins_i.ras_b, pins_i.cas_b, pins_i.we_b} == 3'h4
      |=> cmd_o.valid && cmd_o.op == sdcmd_pkg::OP_WR && cmd_o.bank == $past(pins_i.ba)
          && cmd_o.ap == $past(pins_i.addr[10])) else $error("write decode");
   a_otf_chop: assert property (
      st_r.ctrl[0] && op_now == sdcmd_pkg::OP_WR && !mpr_mode_o
      |=> cmd_o.bc4 == !$past(pins_i.addr[12])) else $error("chop select");
   a_rd_decode: assert property (
      both_hi && {pins_i.ras_b, pins_i.cas_b, pins_i.we_b} == 3'h5
      |=> cmd_o.op == sdcmd_pkg::OP_RD && cmd_o.col == $past({pins_i.addr[11],
          pins_i.addr[9:0]})) else $error("read decode");
   a_sref_cycle: assert property (
      self_ref_o && !pins_i.cke |=> self_ref_o) else $error("self refresh left");
   a_pdn_exit: assert property (
      pwr_down_o && !st_r.cke_prev && pins_i.cke
      && (pins_i.cs_b || {pins_i.ras_b, pins_i.cas_b, pins_i.we_b} == 3'h7)
      |=> !pwr_down_o ##0 cmd_o.op == sdcmd_pkg::OP_PDX) else $error("power down exit");

   c_mpr_read: cover property (mpr_mode_o ##1 cmd_o.valid && cmd_o.mpr);
   c_sref:     cover property ($rose(self_ref_o) ##[1:50] $fell(self_ref_o));
   c_pdn:      cover property ($rose(pwr_down_o) ##[1:50] $fell(pwr_down_o));
   c_wr_otf:   cover property (cmd_o.valid && cmd_o.op == sdcmd_pkg::OP_WR && cmd_o.bc4);
endmodule

// >>> verif/sdcmd_ctl_model.sv
// Behavioural memory controller that drives the command and address pins
`timescale 1ns/1ns
module sdcmd_ctl_model (
   input  wire logic              clk,
   output sdcmd_pkg::sdcmd_pins_t pins_o
);
   // Idle with clock enable high and the device deselected
   initial pins_o = {1'b1, 1'b1, 22'h0};
   // One command for one cycle, then deselect with the don't-care lines toggled
   task automatic drive(input logic ck, input logic [3:0] s, input logic [2:0] ba,
                        input logic [15:0] a);
      @(posedge clk);
      // Register three writes keep reserved address bits at zero
      pins_o <= {ck, s, ba, (s == 4'h0 && ba == 3'h3) ? (a & 16'h0007) : a};
      @(posedge clk);
      pins_o <= {ck, 1'b1, ~pins_o[21:0]};
   endtask
endmodule

// >>> verif/sdram_command_decode_mpr_test.sv
// Self-checking bench of the command decoder
`timescale 1ns/1ns
`include "sdcmd_map.svh"
module sdram_command_decode_mpr_test;
   logic                   clk, rst_b, rtt_nom_only_o, pwr_down_o, self_ref_o, mpr_mode_o;
   sdcmd_pkg::sdcmd_pins_t pins;
   sdcmd_pkg::sdcmd_cmd_t  cmd_o;
   logic [1:0]             rtt_wr_o, s_axi_bresp, s_axi_rresp, rs;
   logic [7:0]             s_axi_awaddr, s_axi_araddr;
   logic [31:0]            s_axi_wdata, s_axi_rdata, q;
   logic [3:0]             s_axi_wstrb;
   logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                   s_axi_rvalid, s_axi_rready;
   int                     n_mismatch, tests_run;
   // Device under test and the controller in front of it
   sdcmd_decode i_sdcmd_decode (.clk, .rst_b, .pins_i(pins), .cmd_o, .rtt_wr_o, .rtt_nom_only_o,
      .pwr_down_o, .self_ref_o, .mpr_mode_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   sdcmd_ctl_model i_sdcmd_ctl_model (.clk, .pins_o(pins));
   // Compare one value
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Report and end the run
   task stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One register access; ready is sampled before the edge that acts on it
   task automatic axi(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      int   i;
      logic a, w, r;
      @(posedge clk);
      if (wr) begin
         s_axi_awaddr <= ad; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= ad; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      end
      for (i = 0; i < 20; i++) begin
         @(negedge clk);
         a = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
         w = s_axi_wvalid && s_axi_wready;
         r = wr ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata;
         rs = wr ? s_axi_bresp : s_axi_rresp;
         @(posedge clk);
         if (a) begin
            s_axi_awvalid <= 1'b0; s_axi_arvalid <= 1'b0;
         end
         if (w) s_axi_wvalid <= 1'b0;
         if (r) break;
      end
      s_axi_bready <= 1'b0; s_axi_rready <= 1'b0;
      if (i == 20) begin
         n_mismatch++;
         stop_test;
      end
   endtask
   // Issue a command and wait a few cycles for its decode
   task automatic cmd(input logic ck, input logic [3:0] s, input logic [2:0] ba,
                      input logic [15:0] a, input sdcmd_pkg::sdcmd_op_t op);
      int i;
      i_sdcmd_ctl_model.drive(ck, s, ba, a);
      #1;
      for (i = 0; i < 4 && cmd_o.valid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk("op", op, (i < 4) ? cmd_o.op : sdcmd_pkg::OP_NONE);
   endtask
   // Register reset values and an unmapped address
   task t_regs;
      axi(1'b0, `SDC_OFF_CTRL, 32'h0); chk("ctrl", 32'h1, q);
      axi(1'b0, `SDC_OFF_STAT, 32'h0); chk("stat", 32'h1, q);
      axi(1'b0, 8'h40, 32'h0); chk("rresp", `SDC_RESP_SLV, rs);
      axi(1'b1, 8'h40, 32'h5); chk("bresp", `SDC_RESP_SLV, rs);
   endtask
   // Each command kind with clock enable held high decoded; row of an activate, column of a write, bank, auto precharge and chop of some
   task t_decode;
      cmd(1'b1, 4'h3, 3'h5, 16'h1234, sdcmd_pkg::OP_ACT);
      chk("row", 32'h1234, cmd_o.row);
      cmd(1'b1, 4'h4, 3'h5, 16'h0A07, sdcmd_pkg::OP_WR);
      chk("col", 32'h607, cmd_o.col);
      chk("apbc", 32'h1, {cmd_o.ap, cmd_o.bc4});
      cmd(1'b1, 4'h4, 3'h5, 16'h1400, sdcmd_pkg::OP_WR);
      chk("apbc", 32'h2, {cmd_o.ap, cmd_o.bc4});
      cmd(1'b1, 4'h3, 3'h2, 16'h0000, sdcmd_pkg::OP_ACT);
      cmd(1'b1, 4'h5, 3'h2, 16'h1000, sdcmd_pkg::OP_RD);
      chk("apbc", 32'h0, {cmd_o.ap, cmd_o.bc4});
      chk("bank", 32'h2, cmd_o.bank);
      cmd(1'b1, 4'h5, 3'h2, 16'h0400, sdcmd_pkg::OP_RD);
      chk("apbc", 32'h3, {cmd_o.ap, cmd_o.bc4});
      cmd(1'b1, 4'h2, 3'h1, 16'h0000, sdcmd_pkg::OP_PRE);
      chk("bank", 32'h1, cmd_o.bank);
      cmd(1'b1, 4'h2, 3'h0, 16'h0400, sdcmd_pkg::OP_PREA);
      cmd(1'b1, 4'h6, 3'h0, 16'h0400, sdcmd_pkg::OP_ZQCL);
      cmd(1'b1, 4'h6, 3'h0, 16'h0000, sdcmd_pkg::OP_ZQCS);
      cmd(1'b1, 4'h1, 3'h0, 16'h0000, sdcmd_pkg::OP_REF);
      cmd(1'b1, 4'h7, 3'h0, 16'h0000, sdcmd_pkg::OP_NOP);
      cmd(1'b1, 4'hF, 3'h0, 16'h0000, sdcmd_pkg::OP_NONE);
      cmd(1'b1, 4'h0, 3'h2, 16'h0400, sdcmd_pkg::OP_MRS);
      chk("rtt", 32'h2, rtt_wr_o);
   endtask
   // Leveling forces nominal termination only; fixed chop ignores A12
   task t_level;
      axi(1'b1, `SDC_OFF_CTRL, 32'h6); chk("lvl", 32'h4, {rtt_nom_only_o, rtt_wr_o});
      cmd(1'b1, 4'h4, 3'h0, 16'h1000, sdcmd_pkg::OP_WR);
      chk("bc4", 32'h1, cmd_o.bc4);
      axi(1'b1, `SDC_OFF_CTRL, 32'h1); chk("lvl", 32'h2, {rtt_nom_only_o, rtt_wr_o});
   endtask
   // Power down and self refresh entry and exit
   task t_power;
      cmd(1'b0, 4'h7, 3'h0, 16'h0000, sdcmd_pkg::OP_PDE); chk("pdn", 32'h1, pwr_down_o);
      cmd(1'b1, 4'h7, 3'h0, 16'h0000, sdcmd_pkg::OP_PDX); chk("pdn", 32'h0, pwr_down_o);
      cmd(1'b0, 4'h1, 3'h0, 16'h0000, sdcmd_pkg::OP_SRE); chk("srf", 32'h1, self_ref_o);
      cmd(1'b1, 4'hF, 3'h0, 16'h0000, sdcmd_pkg::OP_SRX); chk("srf", 32'h0, self_ref_o);
   endtask
   // Pattern reads, a refused command, reset during the mode, location three read, then a normal read
   task t_mpr;
      axi(1'b1, `SDC_OFF_STAT, 32'h100);
      cmd(1'b1, 4'h0, 3'h3, 16'h0004, sdcmd_pkg::OP_MRS);
      chk("mpr", 32'h1, mpr_mode_o);
      cmd(1'b1, 4'h5, 3'h0, 16'h0000, sdcmd_pkg::OP_RD);
      chk("pat", {1'b1, `SDC_MPR_PAT0}, {cmd_o.mpr, cmd_o.mpr_data});
      cmd(1'b1, 4'h3, 3'h0, 16'h0000, sdcmd_pkg::OP_NONE);
      axi(1'b0, `SDC_OFF_STAT, 32'h0); chk("stat", 32'h108, q);
      rst_b <= 1'b0;
      @(posedge clk);
      chk("mpr", 32'h0, mpr_mode_o);
      rst_b <= 1'b1;
      i_sdcmd_ctl_model.drive(1'b1, 4'hF, 3'h0, 16'h0000);
      // Location three in the mode reads the reserved value, then leave the mode
      cmd(1'b1, 4'h0, 3'h3, 16'h0007, sdcmd_pkg::OP_MRS);
      cmd(1'b1, 4'h5, 3'h0, 16'h0000, sdcmd_pkg::OP_RD);
      chk("pat", {1'b1, `SDC_MPR_RSVD}, {cmd_o.mpr, cmd_o.mpr_data});
      cmd(1'b1, 4'h0, 3'h3, 16'h0003, sdcmd_pkg::OP_MRS);
      chk("mpr", 32'h0, mpr_mode_o);
      cmd(1'b1, 4'h5, 3'h0, 16'h0000, sdcmd_pkg::OP_RD);
      chk("pat", 32'h0, {cmd_o.mpr, cmd_o.mpr_data});
   endtask
   // Clock of 40 ns
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Main sequence
   initial begin
      rst_b = 1'b0; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      n_mismatch = 0; tests_run = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      i_sdcmd_ctl_model.drive(1'b1, 4'hF, 3'h0, 16'h0000);
      t_regs; t_decode; t_level; t_power; t_mpr;
      stop_test;
   end
endmodule
